//--- include/fmp_defines.vh
// constants for the floating-point multiply datapath
// assumes the host core issues one instruction per cycle on pclk
`ifndef FMP_DEFINES_VH
`define FMP_DEFINES_VH

`define FMP_OFF_STATUS   8'h00
`define FMP_OFF_CTRL     8'h04
`define FMP_OFF_INT_STAT 8'h08
`define FMP_OFF_INT_MASK 8'h0c
`define FMP_OFF_FREG     8'h20

`define FMP_ST_TEST      0
`define FMP_ST_INT_ZERO  1
`define FMP_ST_INT_NEG   2
`define FMP_ST_FLT_ZERO  3
`define FMP_ST_FLT_NEG   4
`define FMP_ST_UNDER     5
`define FMP_ST_OVER      6

`define FMP_INT_UNDER    0
`define FMP_INT_OVER     1

`define FMP_CTRL_RST     1'b1
`define FMP_MASK_RST     2'b00

`define FMP_OP_IMM_FIRST 10'b1110100001
`define FMP_OP_IMM_LAST  12'b111010000111
`define FMP_OP_RR        16'he700
`define FMP_OP_PAIR_ADD  14'b11100111010000
`define FMP_OP_PAR_LOAD  12'b111000110000

`define FMP_EXP_BIAS     10'd127
`define FMP_EXP_MAX      10'd255
`define FMP_FLT_MAXMAG   31'h7f7fffff

`endif

//--- logic/fmp_core.v
// floating-point multiply datapath with immediate, paired-add and load forms
// assumes instruction words and the memory word arrive synchronous to pclk
`include "fmp_defines.vh"

module fmp_core #(
	parameter ADDR_W = 8
) (
	input  wire              pclk,        // core clock
	input  wire              presetn,     // async reset, active low
	input  wire              psel,        // apb select
	input  wire              penable,     // apb access phase
	input  wire              pwrite,      // apb direction
	input  wire [ADDR_W-1:0] paddr,       // apb byte address
	input  wire [31:0]       pwdata,      // apb write data
	output reg  [31:0]       prdata,      // apb read data
	output reg               pready,      // apb ready
	output reg               pslverr,     // apb error on unmapped address
	input  wire              ins_valid,   // instruction issued this cycle
	input  wire [15:0]       ins_lsw,     // first instruction word
	input  wire [15:0]       ins_msw,     // second instruction word
	input  wire [31:0]       mem_rdata,   // memory word for the parallel load
	input  wire              flag_xfer,   // flag transfer executes
	input  wire [1:0]        flag_sel,    // [0] underflow, [1] overflow selected
	output reg  [6:0]        fpu_status,  // status flags
	output reg               irq          // level interrupt
);

	// ****************************************
	// decode kinds
	// ****************************************
	localparam K_NONE = 3'd0;
	localparam K_IMM  = 3'd1;
	localparam K_RR   = 3'd2;
	localparam K_PAIR = 3'd3;
	localparam K_LOAD = 3'd4;

	// ****************************************
	// arithmetic
	// ****************************************
	// truncating, denormals flushed to zero; {under, over, result}
	function [33:0] fmp_mul;
		input [31:0] a;
		input [31:0] b;
		reg        s;
		reg [47:0] p;
		reg [9:0]  e;
		reg [22:0] m;
		begin
			s = a[31] ^ b[31];
			p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
			e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - `FMP_EXP_BIAS;
			if (p[47]) begin
				m = p[46:24];
				e = e + 10'd1;
			end else begin
				m = p[45:23];
			end
			if (a[30:23] == 8'h00 || b[30:23] == 8'h00)
				fmp_mul = {2'b00, s, 31'h0};
			else if (e[9] || e == 10'd0)
				fmp_mul = {2'b10, s, 31'h0};
			else if (e >= `FMP_EXP_MAX)
				fmp_mul = {2'b01, s, `FMP_FLT_MAXMAG};
			else
				fmp_mul = {2'b00, s, e[7:0], m};
		end
	endfunction

	function [33:0] fmp_add;
		input [31:0] a;
		input [31:0] b;
		reg [31:0] x;
		reg [31:0] y;
		reg [7:0]  d;
		reg [24:0] mx;
		reg [24:0] my;
		reg [24:0] r;
		reg [9:0]  e;
		integer    i;
		begin
			if (a[30:0] >= b[30:0]) begin
				x = a;
				y = b;
			end else begin
				x = b;
				y = a;
			end
			d  = x[30:23] - y[30:23];
			mx = {2'b01, x[22:0]};
			my = (d > 8'd24) ? 25'h0 : ({2'b01, y[22:0]} >> d);
			e  = {2'b00, x[30:23]};
			if (x[31] == y[31])
				r = mx + my;
			else
				r = mx - my;
			if (r[24]) begin
				r = {1'b0, r[24:1]};
				e = e + 10'd1;
			end
			for (i = 0; i < 24; i = i + 1) begin
				if (!r[23] && r != 25'h0) begin
					r = {r[23:0], 1'b0};
					e = e - 10'd1;
				end
			end
			if (x[30:23] == 8'h00)
				fmp_add = {2'b00, b};
			else if (y[30:23] == 8'h00)
				fmp_add = {2'b00, x};
			else if (r == 25'h0)
				fmp_add = {2'b00, 32'h0};
			else if (e[9] || e == 10'd0)
				fmp_add = {2'b10, x[31], 31'h0};
			else if (e >= `FMP_EXP_MAX)
				fmp_add = {2'b01, x[31], `FMP_FLT_MAXMAG};
			else
				fmp_add = {2'b00, x[31], e[7:0], r[22:0]};
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	reg [31:0] fr_q [0:7];
	reg [31:0] fr_d [0:7];
	reg        ctrl_en_q;
	reg [1:0]  int_stat_q;
	reg [1:0]  int_stat_d;
	reg [1:0]  int_mask_q;
	reg [6:0]  stf_d;
	reg        pm_vld_q;
	reg [2:0]  pm_dst_q;
	reg [31:0] pm_res_q;
	reg        pa_vld_q;
	reg [2:0]  pa_dst_q;
	reg [31:0] pa_res_q;
	reg        p_uf_q;
	reg        p_ov_q;

	// ****************************************
	// decode
	// ****************************************
	reg [2:0]  kind;
	reg [2:0]  m_dst;
	reg [2:0]  m_sa;
	reg [2:0]  m_sb;
	reg [2:0]  a_dst;
	reg [2:0]  a_sa;
	reg [2:0]  a_sb;
	reg [31:0] imm_op;
	reg        use_imm;

	always @* begin
		kind    = K_NONE;
		m_dst   = ins_msw[2:0];
		m_sa    = ins_msw[5:3];
		m_sb    = ins_msw[8:6];
		a_dst   = ins_msw[11:9];
		a_sa    = ins_msw[14:12];
		a_sb    = {ins_lsw[1:0], ins_msw[15]};
		imm_op  = {ins_lsw[5:0], ins_msw[15:6], 16'h0};
		use_imm = 1'b0;
		if (ins_valid && ctrl_en_q) begin
			// immediate-last also matches the immediate-first pattern, so it goes first
			if (ins_lsw[15:4] == `FMP_OP_IMM_LAST) begin
				kind    = K_IMM;
				use_imm = 1'b1;
				imm_op  = {ins_lsw[3:0], ins_msw[15:6], 18'h0};
			end else if (ins_lsw[15:6] == `FMP_OP_IMM_FIRST) begin
				kind    = K_IMM;
				use_imm = 1'b1;
			end else if (ins_lsw == `FMP_OP_RR && ins_msw[15:9] == 7'h00) begin
				kind = K_RR;
			end else if (ins_lsw[15:2] == `FMP_OP_PAIR_ADD) begin
				kind = K_PAIR;
			end else if (ins_lsw[15:4] == `FMP_OP_PAR_LOAD) begin
				kind  = K_LOAD;
				m_dst = ins_msw[13:11];
				m_sa  = {ins_lsw[0], ins_msw[15:14]};
				m_sb  = ins_lsw[3:1];
				a_dst = ins_msw[10:8];
			end
		end
	end

	// ****************************************
	// execute stage
	// ****************************************
	// operand order is irrelevant to the multiplier, so both immediate forms share it
	wire [33:0] mul_r = fmp_mul(fr_q[m_sa], use_imm ? imm_op : fr_q[m_sb]);
	wire [33:0] add_r = fmp_add(fr_q[a_sa], fr_q[a_sb]);
	wire        m_go  = kind != K_NONE;
	wire        a_go  = kind == K_PAIR;
	wire        l_go  = kind == K_LOAD;

	// ****************************************
	// writeback and flags
	// ****************************************
	// a hold-stage flag counts only in the cycle its result lands
	wire       uf_evt = pm_vld_q && p_uf_q;
	wire       ov_evt = pm_vld_q && p_ov_q;
	integer    k;
	integer    n;

	always @* begin
		for (k = 0; k < 8; k = k + 1)
			fr_d[k] = fr_q[k];
		if (pm_vld_q)
			fr_d[pm_dst_q] = pm_res_q;
		if (pa_vld_q)
			fr_d[pa_dst_q] = pa_res_q;
		// load of the next instruction lands on the same edge, ahead of its product
		if (l_go)
			fr_d[a_dst] = mem_rdata;
		stf_d = fpu_status;
		if (flag_xfer && flag_sel[0])
			stf_d[`FMP_ST_UNDER] = 1'b0;
		if (flag_xfer && flag_sel[1])
			stf_d[`FMP_ST_OVER] = 1'b0;
		// a flag raised in the clearing cycle survives
		if (uf_evt)
			stf_d[`FMP_ST_UNDER] = 1'b1;
		if (ov_evt)
			stf_d[`FMP_ST_OVER] = 1'b1;
		if (l_go) begin
			stf_d[`FMP_ST_FLT_NEG]  = mem_rdata[31];
			stf_d[`FMP_ST_FLT_ZERO] = 1'b0;
			if (mem_rdata[30:23] == 8'h00) begin
				stf_d[`FMP_ST_FLT_ZERO] = 1'b1;
				stf_d[`FMP_ST_FLT_NEG]  = 1'b0;
			end
			stf_d[`FMP_ST_INT_NEG]  = mem_rdata[31];
			stf_d[`FMP_ST_INT_ZERO] = mem_rdata == 32'h0;
		end
	end

	// ****************************************
	// apb slave
	// ****************************************
	wire       acc    = psel && penable && !pready;
	wire       wr     = acc && pwrite;
	wire       is_fr  = paddr[ADDR_W-1:5] == `FMP_OFF_FREG >> 5;
	wire       mapped = is_fr || paddr == `FMP_OFF_STATUS || paddr == `FMP_OFF_CTRL
	                    || paddr == `FMP_OFF_INT_STAT || paddr == `FMP_OFF_INT_MASK;
	reg [31:0] rd_mux;

	always @* begin
		rd_mux = 32'h0;
		if (is_fr)
			rd_mux = fr_q[paddr[4:2]];
		else if (paddr == `FMP_OFF_STATUS)
			rd_mux = {25'h0, fpu_status};
		else if (paddr == `FMP_OFF_CTRL)
			rd_mux = {31'h0, ctrl_en_q};
		else if (paddr == `FMP_OFF_INT_STAT)
			rd_mux = {30'h0, int_stat_q};
		else if (paddr == `FMP_OFF_INT_MASK)
			rd_mux = {30'h0, int_mask_q};
	end

	always @* begin
		int_stat_d = int_stat_q;
		if (wr && paddr == `FMP_OFF_INT_STAT)
			int_stat_d = int_stat_q & ~pwdata[1:0];
		if (uf_evt)
			int_stat_d[`FMP_INT_UNDER] = 1'b1;
		if (ov_evt)
			int_stat_d[`FMP_INT_OVER] = 1'b1;
	end

	// ****************************************
	// registers
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (n = 0; n < 8; n = n + 1)
				fr_q[n] <= 32'h0;
			fpu_status <= 7'h00;
			int_stat_q <= 2'b00;
			irq        <= 1'b0;
		end else begin
			for (n = 0; n < 8; n = n + 1)
				fr_q[n] <= fr_d[n];
			fpu_status <= stf_d;
			int_stat_q <= int_stat_d;
			// irq is registered from the next status, so it moves on the same edge as int_stat_q and stays a flop output
			irq        <= |(int_stat_d & int_mask_q);
		end
	end

	// ****************************************
	// hold stage
	// ****************************************
	// one stage of hold, so the product appears two cycles after issue
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pm_vld_q   <= 1'b0;
			pm_dst_q   <= 3'd0;
			pm_res_q   <= 32'h0;
			pa_vld_q   <= 1'b0;
			pa_dst_q   <= 3'd0;
			pa_res_q   <= 32'h0;
			p_uf_q     <= 1'b0;
			p_ov_q     <= 1'b0;
		end else begin
			pm_vld_q   <= m_go;
			pm_dst_q   <= m_dst;
			pm_res_q   <= mul_r[31:0];
			pa_vld_q   <= a_go;
			pa_dst_q   <= a_dst;
			pa_res_q   <= add_r[31:0];
			p_uf_q     <= mul_r[33] | (a_go & add_r[33]);
			p_ov_q     <= mul_r[32] | (a_go & add_r[32]);
		end
	end

	// ****************************************
	// apb registers
	// ****************************************
	// pready drops after one cycle, so a held access is taken only once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_q  <= `FMP_CTRL_RST;
			int_mask_q <= `FMP_MASK_RST;
			prdata     <= 32'h0;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
		end else begin
			pready     <= acc;
			pslverr    <= acc && !mapped;
			if (acc)
				prdata <= (pwrite || !mapped) ? 32'h0 : rd_mux;
			if (wr && paddr == `FMP_OFF_CTRL)
				ctrl_en_q <= pwdata[0];
			if (wr && paddr == `FMP_OFF_INT_MASK)
				int_mask_q <= pwdata[1:0];
		end
	end

endmodule

//--- sim/fmp_core_asserts.sv
// port-level checks for the multiply datapath
// assumes one pclk domain, reset by presetn, bound onto fmp_core
`include "fmp_defines.vh"
// ********
// checker
// ********
module fmp_core_asserts (
	input logic        pclk,       // clock
	input logic        presetn,    // reset
	input logic        psel,       // select
	input logic        penable,    // access
	input logic        pready,     // ready
	input logic        ins_valid,  // issue
	input logic [15:0] ins_lsw,    // first word
	input logic [31:0] mem_rdata,  // load word
	input logic        flag_xfer,  // flag clear
	input logic [1:0]  flag_sel,   // clear select
	input logic [6:0]  fpu_status  // flags
);
	timeunit 1ns;
	timeprecision 1ps;
	wire ld = ins_valid && ins_lsw[15:4] == `FMP_OP_PAR_LOAD;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_ready_next: assert property (psel && penable && !pready |=> pready)
		else $error("no ready after access");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_test_zero: assert property (fpu_status[0] == 1'b0)
		else $error("test flag moved");
	chk_flags_quiet: assert property (!ld |=> $stable(fpu_status[4:1]))
		else $error("zero or negative flag moved");
	chk_load_zero: assert property (ld |=> fpu_status[1] == ($past(mem_rdata) == 32'h0)
		&& fpu_status[3] == ($past(mem_rdata[30:23]) == 8'h00)) else $error("bad zero flags");
	chk_load_neg: assert property (ld |=> fpu_status[2] == $past(mem_rdata[31])
		&& fpu_status[4] == ($past(mem_rdata[31]) && $past(mem_rdata[30:23]) != 8'h00))
		else $error("bad negative flags");
	chk_under_rise: assert property ($rose(fpu_status[5]) |-> $past(ins_valid, 2))
		else $error("underflow latched at wrong time");
	chk_over_rise: assert property ($rose(fpu_status[6]) |-> $past(ins_valid, 2))
		else $error("overflow latched at wrong time");
	chk_under_hold: assert property (fpu_status[5] && !(flag_xfer && flag_sel[0]) |=> fpu_status[5])
		else $error("underflow latch lost");
	chk_over_hold: assert property (fpu_status[6] && !(flag_xfer && flag_sel[1]) |=> fpu_status[6])
		else $error("overflow latch lost");
	cover property (ld);
	cover property ($rose(fpu_status[6]));
	cover property (flag_xfer && fpu_status[5]);
endmodule
bind fmp_core fmp_core_asserts fmp_core_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .ins_valid(ins_valid), .ins_lsw(ins_lsw),
	.mem_rdata(mem_rdata), .flag_xfer(flag_xfer), .flag_sel(flag_sel), .fpu_status(fpu_status));

//--- sim/fmp_core_tb.sv
// self-checking bench for the multiply datapath
// assumes fmp_core with default address width, driven by fmp_host
`include "fmp_defines.vh"
// ********
// bench
// ********
module fmp_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	wire  [31:0] prdata, mem_rdata;
	wire         pready, pslverr, ins_valid, flag_xfer, irq;
	wire  [15:0] ins_lsw, ins_msw;
	wire  [1:0]  flag_sel;
	wire  [6:0]  fpu_status;
	logic [31:0] fr [8] = '{default: 32'h0};
	logic [31:0] cw [4] = '{32'h0, 32'h80000000, 32'h00800000, 32'h80800000};
	logic [6:0]  exp_st = 0;
	logic [1:0]  exp_int = 0;
	int          num_errors = 0, checks_done = 0;
	always #25 pclk = ~pclk;
	fmp_core fmp_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ins_valid(ins_valid), .ins_lsw(ins_lsw), .ins_msw(ins_msw),
		.mem_rdata(mem_rdata), .flag_xfer(flag_xfer), .flag_sel(flag_sel),
		.fpu_status(fpu_status), .irq(irq));
	fmp_host fmp_host_i (.pclk(pclk), .ins_valid(ins_valid), .ins_lsw(ins_lsw),
		.ins_msw(ins_msw), .mem_rdata(mem_rdata), .flag_xfer(flag_xfer), .flag_sel(flag_sel));
	task automatic wrap_up();
		if (num_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] ex);
		checks_done++;
		if (seen !== ex) begin
			$display("ERROR %s expected %h seen %h", n, ex, seen);
			num_errors++;
		end
	endtask
	// truncating product, {overflow, underflow, word}; zero exponent reads as zero
	function automatic logic [33:0] mul(input logic [31:0] x, input logic [31:0] y);
		logic [47:0] m;
		int          e;
		logic        s;
		s = x[31] ^ y[31];
		if (x[30:23] == 0 || y[30:23] == 0) return {2'b00, s, 31'h0};
		m = {1'b1, x[22:0]} * {1'b1, y[22:0]};
		e = x[30:23] + y[30:23] - 127;
		if (m[47]) e++;
		else m = m << 1;
		if (e >= 255) return {2'b10, s, 31'h7f7fffff};
		if (e <= 0) return {2'b01, s, 31'h0};
		return {2'b00, s, e[7:0], m[46:24]};
	endfunction
	function automatic logic [31:0] rnd_word();
		return {1'($urandom), 8'(96 + $urandom % 63), 23'($urandom)};
	endfunction
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
			output logic [31:0] rd, output logic er);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk iff pready === 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		logic [31:0] rd;
		logic        er;
		apb(1'b1, ad, wd, rd, er);
	endtask
	task automatic rdchk(input logic [7:0] ad, input logic [31:0] ex, input logic ee);
		logic [31:0] rd;
		logic        er;
		apb(1'b0, ad, 32'h0, rd, er);
		check($sformatf("read %h", ad), rd, ex);
		check("pslverr", 32'(er), 32'(ee));
	endtask
	task automatic regs();
		for (int i = 0; i < 8; i++) rdchk(8'(`FMP_OFF_FREG + 4 * i), fr[i], 1'b0);
	endtask
	// k: 0 load form, 1 immediate first, 2 immediate last, 3 paired add with r7, 4 plain
	task automatic op(input int k, input logic [2:0] a, b, c, d, input logic [31:0] w,
			input logic [15:0] im);
		logic [33:0] p;
		logic [31:0] s;
		logic [15:0] l, m;
		p = mul(fr[b], (k == 1 || k == 2) ? {im, 16'h0} : fr[c]);
		s = fr[b];
		case (k)
			0: begin
				{l, m} = {`FMP_OP_PAR_LOAD, c, b, d, a, 8'h00};
			end
			1: begin
				{l, m} = {`FMP_OP_IMM_FIRST, im, b, a};
			end
			2: begin
				{l, m} = {`FMP_OP_IMM_LAST, im[15:2], b, a};
			end
			4: begin
				{l, m} = {`FMP_OP_RR, 7'h00, c, b, a};
			end
			default: begin
				{l, m} = {`FMP_OP_PAIR_ADD, 3'b111, b, d, c, b, a};
			end
		endcase
		fmp_host_i.issue(l, m, w);
		@(posedge pclk);
		fr[k == 0 ? d : a] = p[31:0];
		if (k == 0) fr[a] = w;
		if (k == 0) exp_st[4:1] = {w[31] && w[30:23] != 0, w[30:23] == 0, w[31], w == 0};
		// a zero or flushed operand plus r7 comes back as plus zero
		if (k == 3) fr[d] = (s[30:23] == 8'h00) ? 32'h0 : s;
		exp_st[6:5] |= p[33:32];
		exp_int |= p[33:32];
		check("status", 32'(fpu_status), 32'(exp_st));
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		wrap_up();
	end
	initial begin
		logic [2:0]  a;
		logic [15:0] im;
		void'($urandom(32'h79bdef73));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(`FMP_OFF_CTRL, 32'h1, 1'b0);
		rdchk(`FMP_OFF_INT_MASK, 32'h0, 1'b0);
		// r7 stays zero so the paired add is exact without an adder model
		for (int i = 0; i < 7; i++) op(0, 3'(i), 3'd7, 3'd7, 3'd7, rnd_word(), 16'h0);
		for (int i = 0; i < 60; i++) begin
			a = 3'($urandom % 7);
			im = {1'($urandom), 8'(112 + $urandom % 16), 5'($urandom), 2'b00};
			op(int'($urandom % 5), a, 3'($urandom % 7), 3'($urandom % 7),
				3'((a + 1 + $urandom % 6) % 7), rnd_word(), im);
		end
		regs();
		fmp_host_i.clear(2'b11);
		exp_st[6:5] = 2'b00;
		check("cleared", 32'(fpu_status), 32'(exp_st));
		wr(`FMP_OFF_INT_STAT, 32'h3);
		exp_int = 2'b00;
		for (int j = 0; j < 4; j++) op(0, 3'(j % 2), 3'd7, 3'd7, 3'd5, cw[j], 16'h0);
		op(3, 3'd2, 3'd0, 3'd1, 3'd3, 32'h0, 16'h0);
		op(0, 3'd0, 3'd7, 3'd7, 3'd5, 32'h7f000000, 16'h0);
		op(1, 3'd4, 3'd0, 3'd0, 3'd6, 32'h0, 16'h7f00);
		op(1, 3'd5, 3'd3, 3'd0, 3'd6, 32'h0, 16'h4040);
		op(2, 3'd6, 3'd3, 3'd0, 3'd1, 32'h0, 16'h4040);
		op(4, 3'd1, 3'd3, 3'd5, 3'd0, 32'h0, 16'h0);
		fmp_host_i.clear(2'b01);
		exp_st[5] = 1'b0;
		check("clear one", 32'(fpu_status), 32'(exp_st));
		rdchk(`FMP_OFF_INT_STAT, 32'(exp_int), 1'b0);
		check("irq", 32'(irq), 32'h0);
		wr(`FMP_OFF_INT_MASK, 32'h1);
		check("irq", 32'(irq), 32'h1);
		wr(`FMP_OFF_INT_STAT, 32'h1);
		check("irq", 32'(irq), 32'h0);
		rdchk(`FMP_OFF_INT_STAT, 32'h2, 1'b0);
		wr(`FMP_OFF_INT_MASK, 32'h2);
		check("irq", 32'(irq), 32'h1);
		// issue off: nothing lands; the word's flags equal the present ones on purpose
		wr(`FMP_OFF_CTRL, 32'h0);
		fmp_host_i.issue({`FMP_OP_PAR_LOAD, 4'h0}, 16'h0700, 32'h5a5a5a5a);
		rdchk(`FMP_OFF_CTRL, 32'h0, 1'b0);
		wr(`FMP_OFF_CTRL, 32'h1);
		rdchk(8'h40, 32'h0, 1'b1);
		rdchk(`FMP_OFF_STATUS, 32'(exp_st), 1'b0);
		regs();
		wrap_up();
	end
endmodule

//--- sim/fmp_host.sv
// issuing core model: instructions, memory word and flag transfers
// assumes calls start just after a rising edge of pclk
// ********
// host core
// ********
module fmp_host (
	input  logic        pclk,       // clock
	output logic        ins_valid,  // issue
	output logic [15:0] ins_lsw,    // first word
	output logic [15:0] ins_msw,    // second word
	output logic [31:0] mem_rdata,  // load word
	output logic        flag_xfer,  // flag clear
	output logic [1:0]  flag_sel    // clear select
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {ins_valid, ins_lsw, ins_msw, mem_rdata, flag_xfer, flag_sel} = '0;
	// free slot after every issue, so no delay-slot hazard is ever made
	task automatic issue(input logic [15:0] l, input logic [15:0] m, input logic [31:0] w);
		ins_valid <= 1'b1;
		ins_lsw <= l;
		ins_msw <= m;
		mem_rdata <= w;
		@(posedge pclk);
		ins_valid <= 1'b0;
		ins_lsw <= ~l;
		ins_msw <= ~m;
		mem_rdata <= ~w;
		@(posedge pclk);
	endtask
	task automatic clear(input logic [1:0] s);
		flag_xfer <= 1'b1;
		flag_sel <= s;
		@(posedge pclk);
		flag_xfer <= 1'b0;
		flag_sel <= ~s;
		@(posedge pclk);
	endtask
endmodule
